/* design/function_control_reg.sv */
// command word storage of one pci function
`timescale 1ns/100ps

module function_control_reg
(
    // clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_n,
    // write strobe with byte enables for the low dword half
    input  wire logic                      i_wr,
    input  wire logic [1:0]                i_byte_en,
    input  wire logic [15:0]               i_wdata,
    // stored word and decoded fields
    output logic      [15:0]               o_word,
    output pci_cfg_pkg::cmd_fields_t       o_fields
);

    logic [15:0] cmd;
    logic [15:0] lane_mask;

    // merge only enabled lanes, and only bits that are writable
    assign lane_mask = {{8{i_byte_en[1]}}, {8{i_byte_en[0]}}} & pci_cfg_pkg::CMD_WRITE_MASK;

    // hardwired and reserved bits never leave zero since the mask keeps them out
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cmd <= pci_cfg_pkg::CMD_RESET;
        else if (i_wr)
            cmd <= (cmd & ~lane_mask) | (i_wdata & lane_mask);
    end

    assign o_word = cmd;

    // field decode
    always_comb
    begin
        o_fields.int_disable                = cmd[pci_cfg_pkg::BIT_INT_DISABLE];
        o_fields.system_error_driver_enable = cmd[pci_cfg_pkg::BIT_SYS_ERR];
        o_fields.parity_response_enable     = cmd[pci_cfg_pkg::BIT_PAR_RESP];
        o_fields.palette_snoop              = cmd[pci_cfg_pkg::BIT_PAL_SNOOP];
        o_fields.initiator_enable           = cmd[pci_cfg_pkg::BIT_INIT_EN];
        o_fields.mem_enable                 = cmd[pci_cfg_pkg::BIT_MEM_EN];
        o_fields.io_enable                  = cmd[pci_cfg_pkg::BIT_IO_EN];
    end

endmodule : function_control_reg

/* design/pci_function_command_config.sv */
// identification word and per-function command registers of a two-function pci device
`timescale 1ns/100ps

module pci_function_command_config
(
    // clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_n,
    // configuration request from the pci target logic
    input  wire pci_cfg_pkg::cfg_req_t     i_cfg,
    // configuration answer
    output logic                           o_cfg_ack,
    output logic [31:0]                    o_cfg_rdata,
    // per-function decode hits and requests from the bus logic
    input  wire logic [1:0]                i_io_hit,
    input  wire logic [1:0]                i_mem_hit,
    input  wire logic [1:0]                i_palette_write,
    input  wire logic [1:0]                i_bus_req,
    input  wire logic [1:0]                i_irq,
    input  wire logic [1:0]                i_was_master,
    // shared parity events from the bus logic
    input  wire logic                      i_addr_parity_err,
    input  wire logic                      i_data_parity_err,
    input  wire logic                      i_perr_seen,
    // gated outputs to the bus logic
    output logic [1:0]                     o_io_claim,
    output logic [1:0]                     o_mem_claim,
    output logic [1:0]                     o_palette_snoop,
    output logic [1:0]                     o_bus_req,
    output logic [1:0]                     o_intx_req,
    output logic                           o_special_claim,
    output logic                           o_back_to_back,
    output logic                           o_write_invalidate,
    // error pins, active-low open drain, enable high while pulling low
    output logic                           o_serr_oe,
    output logic                           o_perr_oe
);

    logic [15:0]                 cmd_word [pci_cfg_pkg::NUM_FUNCS];
    pci_cfg_pkg::cmd_fields_t    fields   [pci_cfg_pkg::NUM_FUNCS];
    logic [1:0]                  cmd_wr;
    logic [1:0]                  master_data_parity_flag;
    logic [1:0]                  flag_clear;
    logic [1:0]                  flag_set;
    logic                        serr_any;
    logic                        perr_any;
    logic [1:0]                  status_lanes;

    // byte lanes 0 and 1 of a dword
    function automatic logic [1:0] low_lanes(input logic [3:0] be);
        low_lanes = be[1:0];
    endfunction : low_lanes

    function automatic logic [1:0] high_lanes(input logic [3:0] be);
        high_lanes = be[3:2];
    endfunction : high_lanes

    // write decode, one command register per function
    always_comb
    begin
        cmd_wr = 2'b00;
        if (i_cfg.valid && i_cfg.write && i_cfg.dword == pci_cfg_pkg::DW_CONTROL)
            cmd_wr[i_cfg.func] = 1'b1;
    end

    // command registers; the identifier word has no storage at all, so writes cannot touch it
    for (genvar f = 0; f < pci_cfg_pkg::NUM_FUNCS; f++)
    begin : g_func
        function_control_reg u_cmd
        (
            .i_clk     (i_clk),
            .i_rst_n   (i_rst_n),
            .i_wr      (cmd_wr[f]),
            .i_byte_en (low_lanes(i_cfg.byte_en)),
            .i_wdata   (i_cfg.wdata[15:0]),
            .o_word    (cmd_word[f]),
            .o_fields  (fields[f])
        );
    end

    // shared error enables seen by both functions
    assign serr_any = fields[0].system_error_driver_enable | fields[1].system_error_driver_enable;
    assign perr_any = fields[0].parity_response_enable | fields[1].parity_response_enable;

    // byte lanes of the status half; a function result cannot be indexed directly
    assign status_lanes = high_lanes(i_cfg.byte_en);

    // master data parity flag: write one to clear on the status half, set wins over clear
    always_comb
    begin
        flag_clear = 2'b00;
        flag_set   = 2'b00;
        for (int f = 0; f < pci_cfg_pkg::NUM_FUNCS; f++)
        begin
            flag_set[f] = i_perr_seen & i_was_master[f] & fields[f].parity_response_enable;
        end
        if (i_cfg.valid && i_cfg.write && i_cfg.dword == pci_cfg_pkg::DW_CONTROL
            && status_lanes[1] && i_cfg.wdata[16 + pci_cfg_pkg::BIT_MDPAR_FLAG])
            flag_clear[i_cfg.func] = 1'b1;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            master_data_parity_flag <= 2'b00;
        else
            master_data_parity_flag <= flag_set | (master_data_parity_flag & ~flag_clear);
    end

    // configuration read and acknowledge, one cycle after the request
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_cfg_ack   <= 1'b0;
            o_cfg_rdata <= 32'h00000000;
        end
        else
        begin
            o_cfg_ack <= i_cfg.valid;
            if (i_cfg.valid && !i_cfg.write)
            begin
                case (i_cfg.dword)
                    pci_cfg_pkg::DW_IDENT:
                        o_cfg_rdata <= {pci_cfg_pkg::IDENT_VALUE, pci_cfg_pkg::VENDOR_READ};
                    pci_cfg_pkg::DW_CONTROL:
                        o_cfg_rdata <= {(pci_cfg_pkg::STATUS_RESET
                                         | (16'(master_data_parity_flag[i_cfg.func])
                                            << pci_cfg_pkg::BIT_MDPAR_FLAG)),
                                        cmd_word[i_cfg.func]};
                    default:
                        o_cfg_rdata <= 32'h00000000;   // other dwords lie outside this block
                endcase
            end
        end
    end

    // target claims gated by the space enables; palette writes under snoop leave the io claim off, the memory claim is not affected
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_io_claim      <= 2'b00;
            o_mem_claim     <= 2'b00;
            o_palette_snoop <= 2'b00;
        end
        else
        begin
            for (int f = 0; f < pci_cfg_pkg::NUM_FUNCS; f++)
            begin
                o_io_claim[f]      <= i_io_hit[f] & fields[f].io_enable
                                      & ~(i_palette_write[f] & fields[f].palette_snoop);
                o_mem_claim[f]     <= i_mem_hit[f] & fields[f].mem_enable;
                o_palette_snoop[f] <= i_palette_write[f] & fields[f].palette_snoop;
            end
        end
    end

    // initiator requests and interrupt requests
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_bus_req  <= 2'b00;
            o_intx_req <= 2'b00;
        end
        else
        begin
            for (int f = 0; f < pci_cfg_pkg::NUM_FUNCS; f++)
            begin
                o_bus_req[f]  <= i_bus_req[f] & fields[f].initiator_enable;
                o_intx_req[f] <= i_irq[f] & ~fields[f].int_disable;
            end
        end
    end

    // hardwired capabilities: never asserted, kept as flops so outputs stay registered
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_special_claim    <= 1'b0;
            o_back_to_back     <= 1'b0;
            o_write_invalidate <= 1'b0;
        end
        else
        begin
            o_special_claim    <= 1'b0;
            o_back_to_back     <= 1'b0;
            o_write_invalidate <= 1'b0;
        end
    end

    // error pins; address parity needs both shared enables, data parity only the parity enable
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_serr_oe <= 1'b0;
            o_perr_oe <= 1'b0;
        end
        else
        begin
            o_serr_oe <= i_addr_parity_err & serr_any & perr_any;
            o_perr_oe <= i_data_parity_err & perr_any;
        end
    end

endmodule : pci_function_command_config

/* shared/pci_cfg_pkg.sv */
// constants and carrier types for the per-function identification and command registers
package pci_cfg_pkg;

    // configuration dword indices (byte offset / 4)
    localparam logic [5:0]  DW_IDENT         = 6'h00;   // vendor word low, identifier word high
    localparam logic [5:0]  DW_CONTROL       = 6'h01;   // command word low, status word high
    localparam logic [7:0]  OFS_IDENT        = 8'h02;   // byte offset of the identifier word
    localparam logic [7:0]  OFS_CONTROL      = 8'h04;   // byte offset of the command word

    // identifier value, arbitrary and neutral
    localparam logic [15:0] IDENT_VALUE      = 16'h5a01;

    // command word bit positions
    localparam int          BIT_IO_EN        = 0;
    localparam int          BIT_MEM_EN       = 1;
    localparam int          BIT_INIT_EN      = 2;
    localparam int          BIT_SPECIAL      = 3;
    localparam int          BIT_WR_INVAL     = 4;
    localparam int          BIT_PAL_SNOOP    = 5;
    localparam int          BIT_PAR_RESP     = 6;
    localparam int          BIT_SYS_ERR      = 8;
    localparam int          BIT_B2B_GEN      = 9;
    localparam int          BIT_INT_DISABLE  = 10;

    // status word bit position of the master data parity flag
    localparam int          BIT_MDPAR_FLAG   = 8;

    // writable bits of the command word; everything else reads zero
    localparam logic [15:0] CMD_WRITE_MASK   = 16'h0567;
    localparam logic [15:0] CMD_RESET        = 16'h0000;
    localparam logic [15:0] STATUS_RESET     = 16'h0000;
    localparam logic [15:0] VENDOR_READ      = 16'h0000;

    localparam int          NUM_FUNCS        = 2;

    // decoded command word of one function
    typedef struct packed {
        logic int_disable;
        logic system_error_driver_enable;
        logic parity_response_enable;
        logic palette_snoop;
        logic initiator_enable;
        logic mem_enable;
        logic io_enable;
    } cmd_fields_t;

    // one configuration request from the pci target logic
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        func;
        logic [5:0]  dword;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } cfg_req_t;

endpackage : pci_cfg_pkg

/* tb/cmd_config_assertions.sv */
// concurrent checks on the ports of the command register block
`timescale 1ns/100ps

module cmd_config_checker
(
    // clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    // configuration port
    input  wire pci_cfg_pkg::cfg_req_t i_cfg,
    input  wire logic                  o_cfg_ack,
    input  wire logic [31:0]           o_cfg_rdata,
    // decode inputs and gated outputs
    input  wire logic [1:0]            i_io_hit,
    input  wire logic [1:0]            i_mem_hit,
    input  wire logic [1:0]            i_palette_write,
    input  wire logic [1:0]            o_io_claim,
    input  wire logic [1:0]            o_mem_claim,
    input  wire logic [1:0]            o_palette_snoop,
    input  wire logic                  o_special_claim,
    input  wire logic                  o_back_to_back,
    input  wire logic                  o_write_invalidate,
    // parity events and error pins
    input  wire logic                  i_addr_parity_err,
    input  wire logic                  i_data_parity_err,
    input  wire logic                  o_serr_oe,
    input  wire logic                  o_perr_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // one configuration read of a given dword
    sequence s_read(logic [5:0] dw);
        i_cfg.valid && !i_cfg.write && i_cfg.dword == dw;
    endsequence

    // answers and read data; the claim checks only bound outputs by their causes
    property p_ack; o_cfg_ack == $past(i_cfg.valid); endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle after request");
    property p_hold; !(i_cfg.valid && !i_cfg.write) |=> $stable(o_cfg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    property p_ident; s_read(pci_cfg_pkg::DW_IDENT) |=> o_cfg_rdata[31:16] == pci_cfg_pkg::IDENT_VALUE; endproperty
    a_ident: assert property (p_ident) else $error("identifier word changed");
    property p_rsvd; s_read(pci_cfg_pkg::DW_CONTROL) |=> o_cfg_rdata[15:11] == 5'h00 && !o_cfg_rdata[7]; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved command bits set");
    property p_hard; s_read(pci_cfg_pkg::DW_CONTROL) |=> !(o_cfg_rdata[9] | o_cfg_rdata[4] | o_cfg_rdata[3]); endproperty
    a_hard: assert property (p_hard) else $error("hardwired command bit set");
    property p_fixed; !(o_special_claim | o_back_to_back | o_write_invalidate); endproperty
    a_fixed: assert property (p_fixed) else $error("unsupported cycle type driven");
    property p_mem; (o_mem_claim & ~$past(i_mem_hit)) == 2'b00; endproperty
    a_mem: assert property (p_mem) else $error("memory claim without hit");
    property p_io; (o_io_claim & ~$past(i_io_hit)) == 2'b00; endproperty
    a_io: assert property (p_io) else $error("io claim without hit");
    property p_snoop; (o_palette_snoop & (o_io_claim | ~$past(i_palette_write))) == 2'b00; endproperty
    a_snoop: assert property (p_snoop) else $error("palette snoop wrong");
    property p_serr; o_serr_oe |-> $past(i_addr_parity_err); endproperty
    a_serr: assert property (p_serr) else $error("serr without address parity error");
    property p_perr; o_perr_oe |-> $past(i_data_parity_err); endproperty
    a_perr: assert property (p_perr) else $error("perr without data parity error");
endmodule : cmd_config_checker

bind pci_function_command_config cmd_config_checker i_chk
(
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg(i_cfg), .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata),
    .i_io_hit(i_io_hit), .i_mem_hit(i_mem_hit), .i_palette_write(i_palette_write), .o_io_claim(o_io_claim),
    .o_mem_claim(o_mem_claim), .o_palette_snoop(o_palette_snoop), .o_special_claim(o_special_claim),
    .o_back_to_back(o_back_to_back), .o_write_invalidate(o_write_invalidate), .o_serr_oe(o_serr_oe),
    .i_addr_parity_err(i_addr_parity_err), .i_data_parity_err(i_data_parity_err), .o_perr_oe(o_perr_oe)
);

/* tb/host_cfg_master.sv */
// host side model issuing configuration accesses one at a time
`timescale 1ns/100ps

module host_cfg_master
(
    // clock
    input  wire logic                  i_clk,
    // request out, answer back
    output pci_cfg_pkg::cfg_req_t      o_cfg,
    input  wire logic                  i_ack,
    input  wire logic [31:0]           i_rdata
);
    initial o_cfg = '0;

    // one-cycle strobe per access; released fields are inverted so stale values never look valid
    task automatic xfer(input logic w, f, input logic [5:0] dw, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ok);
        @(negedge i_clk);
        o_cfg = {1'b1, w, f, dw, be, wd};
        @(negedge i_clk);
        o_cfg = {1'b0, ~w, ~f, ~dw, ~be, ~wd};
        ok = i_ack;
        rd = i_rdata;
    endtask : xfer
endmodule : host_cfg_master

/* tb/pci_function_command_config_test.sv */
// self-checking bench for the identifier word and command registers
`timescale 1ns/100ps

module pci_function_command_config_test;
    localparam logic [5:0] CTL = pci_cfg_pkg::DW_CONTROL;
    logic                  i_clk;
    logic                  i_rst_n;
    pci_cfg_pkg::cfg_req_t cfg;
    logic                  ack, aerr, derr, perr_seen, p, serr, perr, spec, b2b, winv;
    logic [31:0]           rdata;
    logic [1:0]            io_hit, mem_hit, pal, bus, irq, master, io_c, mem_c, snoop, breq, intx;
    logic [14:0]           ex, got;
    logic [15:0]           c0, c1;
    logic [15:0]           pc0 [5] = '{16'h0000, 16'hffff, 16'h0100, 16'h0100, 16'h0023};
    logic [15:0]           pc1 [5] = '{16'h0000, 16'h0067, 16'h0040, 16'h0000, 16'h0504};
    int                    bad_count = 0;
    int                    n_checks = 0;
    int                    cyc = 0;

    host_cfg_master i_host (.i_clk(i_clk), .o_cfg(cfg), .i_ack(ack), .i_rdata(rdata));
    pci_function_command_config i_dut
    (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg(cfg), .o_cfg_ack(ack), .o_cfg_rdata(rdata),
        .i_io_hit(io_hit), .i_mem_hit(mem_hit), .i_palette_write(pal), .i_bus_req(bus), .i_irq(irq),
        .i_was_master(master), .i_addr_parity_err(aerr), .i_data_parity_err(derr), .i_perr_seen(perr_seen),
        .o_io_claim(io_c), .o_mem_claim(mem_c), .o_palette_snoop(snoop), .o_bus_req(breq), .o_intx_req(intx),
        .o_special_claim(spec), .o_back_to_back(b2b), .o_write_invalidate(winv), .o_serr_oe(serr), .o_perr_oe(perr)
    );

    // 50 MHz clock
    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] g, e);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // one access; the answer must come back, read data is compared
    task automatic acc(input logic w, f, input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd, e);
        logic [31:0] r;
        logic        ok;
        i_host.xfer(w, f, dw, be, wd, r, ok);
        chk({31'h0, ok}, 32'h1);
        if (!w)
            chk(r, e);
    endtask : acc

    // hang guard, far above the hundred-odd cycles the run needs
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            bad_count++;
            close_out();
        end
    end

    initial
    begin
        i_rst_n = 1'b0;
        {io_hit, mem_hit, pal, bus, irq, master, aerr, derr, perr_seen} = '0;
        repeat (16) @(negedge i_clk);
        i_rst_n = 1'b1;
        acc(1'b0, 1'b0, CTL, 4'h0, 32'h0, 32'h0);
        acc(1'b0, 1'b1, CTL, 4'h0, 32'h0, 32'h0);
        acc(1'b0, 1'b0, pci_cfg_pkg::DW_IDENT, 4'h0, 32'h0, {pci_cfg_pkg::IDENT_VALUE, 16'h0000});
        $display("test reset values done");
        acc(1'b1, 1'b0, CTL, 4'hf, 32'hffff_ffff, 32'h0);
        acc(1'b0, 1'b0, CTL, 4'h0, 32'h0, 32'h0000_0567);
        acc(1'b0, 1'b1, CTL, 4'h0, 32'h0, 32'h0);
        acc(1'b1, 1'b1, CTL, 4'h1, 32'hffff_ffff, 32'h0);
        acc(1'b0, 1'b1, CTL, 4'h0, 32'h0, 32'h0000_0067);
        acc(1'b1, 1'b1, CTL, 4'h2, 32'hffff_ffff, 32'h0);
        acc(1'b0, 1'b1, CTL, 4'h0, 32'h0, 32'h0000_0567);
        acc(1'b1, 1'b0, pci_cfg_pkg::DW_IDENT, 4'hf, 32'hffff_ffff, 32'h0);
        acc(1'b0, 1'b0, pci_cfg_pkg::DW_IDENT, 4'h0, 32'h0, {pci_cfg_pkg::IDENT_VALUE, 16'h0000});
        acc(1'b0, 1'b0, 6'h02, 4'h0, 32'h0, 32'h0);
        $display("test register access done");
        {io_hit, mem_hit, bus, irq, aerr, derr} = '1;
        // each command pair with and without a palette write; the two parity enables cross functions
        for (int i = 0; i < 5; i++)
            for (int k = 0; k < 2; k++)
            begin
                c0 = pc0[i] & pci_cfg_pkg::CMD_WRITE_MASK;
                c1 = pc1[i] & pci_cfg_pkg::CMD_WRITE_MASK;
                acc(1'b1, 1'b0, CTL, 4'h3, {16'h0, pc0[i]}, 32'h0);
                acc(1'b1, 1'b1, CTL, 4'h3, {16'h0, pc1[i]}, 32'h0);
                p = k[0];
                pal = {p, p};
                ex = {c1[0] & ~(p & c1[5]), c0[0] & ~(p & c0[5]), c1[1], c0[1], c1[2], c0[2], ~c1[10], ~c0[10],
                      p & c1[5], p & c0[5], (c0[8] | c1[8]) & (c0[6] | c1[6]), c0[6] | c1[6], 3'b000};
                @(negedge i_clk);
                got = {io_c, mem_c, breq, intx, snoop, serr, perr, spec, b2b, winv};
                chk({17'h0, got}, {17'h0, ex});
            end
        $display("test gating done");
        acc(1'b1, 1'b0, CTL, 4'h3, 32'h0000_0040, 32'h0);
        acc(1'b1, 1'b1, CTL, 4'h3, 32'h0000_0000, 32'h0);
        perr_seen = 1'b1;
        @(negedge i_clk);
        master = 2'b11;
        // the edge before the read already sees perr while master, so the flag is up when read
        acc(1'b0, 1'b0, CTL, 4'h0, 32'h0, 32'h0100_0040);
        perr_seen = 1'b0;
        master = 2'b00;
        @(negedge i_clk);
        acc(1'b0, 1'b0, CTL, 4'h0, 32'h0, 32'h0100_0040);
        acc(1'b0, 1'b1, CTL, 4'h0, 32'h0, 32'h0);
        acc(1'b1, 1'b0, CTL, 4'h8, 32'h0100_0000, 32'h0);
        acc(1'b0, 1'b0, CTL, 4'h0, 32'h0, 32'h0000_0040);
        $display("test parity flag done");
        i_rst_n = 1'b0;
        repeat (3) @(negedge i_clk);
        i_rst_n = 1'b1;
        acc(1'b0, 1'b0, CTL, 4'h0, 32'h0, 32'h0);
        $display("test second reset done");
        close_out();
    end
endmodule : pci_function_command_config_test
